// ### logic/interrupt_merge_and_memory_select.v
`include "irq_merge_map.vh"

module interrupt_merge_and_memory_select (
  input wire sys_clk, // 200 MHz clock
  input wire rst_b, // Async reset, active low
  input wire key_press, // Keypad request level
  input wire listener_req, // Listener request (LACS)
  input wire talker_active, // Bus interface talker-active state
  input wire scan_strobe_fifteen, // Scan counter at code 15
  input wire keypad_clk_en, // Keypad scan clock enable in
  input wire [15:0] mem_addr, // Processor memory address
  input wire mem_req, // Memory cycle in progress
  input wire [7:0] io_addr, // Processor I/O port number
  input wire io_wr, // I/O write strobe
  input wire io_rd, // I/O read strobe
  input wire [7:0] io_wdata, // I/O write data
  output reg [2:0] irq_level_ff, // Interrupt level to processor
  output reg irq_req_ff, // Interrupt request to processor
  output reg pending_irq_latch_ff, // Pending latch state
  output reg keypad_clk_gated_ff, // Gated keypad scan enable
  output reg dac_hold_ff, // DAC, stalls listener handshake
  output reg [3:0] rom_sel_ff, // Program memory selects
  output reg ram_sel_ff, // Data memory select
  output reg [15:0] io_slot_sel_ff, // Off-board I/O module selects
  output reg [7:0] analog_ctrl_ff, // Control lines to analog section
  output reg [1:0] delay_one_shots_ff // One-shot delay outputs
);

  ////////////////////////////////////////////////////////////////
  // Internal state and decoded strobes
  reg talker_d_ff; // Talker-active, one cycle late
  reg listener_src_ff; // Pending request came from listener
  reg [12:0] shot0_cnt_ff; // Short one-shot cycles left
  reg [12:0] shot1_cnt_ff; // Long one-shot cycles left
  wire talker_rise; // Entry into talker-active
  wire clr_strobe; // Write to the latch clear port
  wire board_io_module; // Write to the board I/O module
  wire bus_set; // Bus request timed by strobe
  wire latch_set; // Any set condition this cycle
  wire shot0_fire; // Retrigger of the short one-shot
  wire shot1_fire; // Retrigger of the long one-shot

  ////////////////////////////////////////////////////////////////
  // Shared I/O decoder: port to one-hot slot
  function [15:0] slot_decode;
    input [7:0] port;
    input en;
    begin
      slot_decode = 16'h0000;
      if (en && port[7:4] == 4'h0)
        slot_decode[port[3:0]] = 1'b1;
    end
  endfunction

  // One-shot countdown, shared by both timers
  function [12:0] shot_next;
    input [12:0] cnt;
    input fire;
    input [12:0] load;
    begin
      if (fire)
        shot_next = load;
      else if (cnt != 13'h0000)
        shot_next = cnt - 13'h0001;
      else
        shot_next = 13'h0000;
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // Talker request at each strobe while talker-active
  // edge of talker
  assign talker_rise = talker_active & ~talker_d_ff;
  assign clr_strobe = io_wr && (io_addr == `IO_CLR_PORT);
  assign board_io_module = io_wr && (io_addr == `IO_BOARD_PORT);
  // bus requests timed by strobe
  // A held talker re-arms at each strobe, so a missed edge is not lost
  assign bus_set = scan_strobe_fifteen && (listener_req || talker_rise || talker_active);
  assign latch_set = key_press || bus_set;
  assign shot0_fire = board_io_module && io_wdata[6];
  assign shot1_fire = board_io_module && io_wdata[7];

  ////////////////////////////////////////////////////////////////
  // Delayed talker-active for edge detection; idle low matches reset
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      talker_d_ff <= 1'b0;
    end else begin
      talker_d_ff <= talker_active;
    end
  end

  // Pending latch; a set in the clear cycle wins so no request is lost
  // clear after service
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pending_irq_latch_ff <= 1'b0;
    end else if (latch_set) begin
      pending_irq_latch_ff <= 1'b1;
    end else if (clr_strobe) begin
      pending_irq_latch_ff <= 1'b0;
    end
  end

  // Remembers a listener cause until the latch is cleared
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      listener_src_ff <= 1'b0;
    end else if (latch_set) begin
      listener_src_ff <= listener_src_ff | (bus_set & listener_req);
    end else if (clr_strobe) begin
      listener_src_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // request on level seven
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_req_ff <= 1'b0;
    end else begin
      irq_req_ff <= pending_irq_latch_ff;
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_level_ff <= 3'h0;
    end else begin
      irq_level_ff <= pending_irq_latch_ff ? `IRQ_LEVEL : 3'h0;
    end
  end

  // freeze scan clock
  // Raw key also gates, so the scan stops in the same cycle the latch shows
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      keypad_clk_gated_ff <= 1'b0;
    end else begin
      keypad_clk_gated_ff <= keypad_clk_en & ~pending_irq_latch_ff & ~key_press;
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dac_hold_ff <= 1'b0;
    end else begin
      dac_hold_ff <= listener_src_ff;
    end
  end

  ////////////////////////////////////////////////////////////////
  // 4 kbyte program memory
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rom_sel_ff <= 4'h0;
    end else begin
      rom_sel_ff <= 4'h0;
      if (mem_req && mem_addr[15:12] == `ROM_BASE_HI)
        rom_sel_ff[mem_addr[11:10]] <= 1'b1;
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ram_sel_ff <= 1'b0;
    end else begin
      ram_sel_ff <= mem_req && (mem_addr[15:10] == `RAM_BASE_HI);
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      io_slot_sel_ff <= 16'h0000;
    end else begin
      io_slot_sel_ff <= slot_decode(io_addr, io_wr | io_rd);
    end
  end

  ////////////////////////////////////////////////////////////////
  // drive analog lines
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      analog_ctrl_ff <= `CTRL_RST;
    end else if (board_io_module) begin
      analog_ctrl_ff <= io_wdata;
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      shot0_cnt_ff <= 13'h0000;
    end else begin
      shot0_cnt_ff <= shot_next(shot0_cnt_ff, shot0_fire, `SHOT0_CYC);
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      shot1_cnt_ff <= 13'h0000;
    end else begin
      shot1_cnt_ff <= shot_next(shot1_cnt_ff, shot1_fire, `SHOT1_CYC);
    end
  end

  // one-shot outputs
  // High from the write edge for exactly the loaded count of cycles
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      delay_one_shots_ff <= 2'h0;
    end else begin
      delay_one_shots_ff <= {(shot1_cnt_ff > 13'h0001) || shot1_fire,
                             (shot0_cnt_ff > 13'h0001) || shot0_fire};
    end
  end

endmodule // interrupt_merge_and_memory_select

// ### pkg/irq_merge_map.vh
`ifndef IRQ_MERGE_MAP_VH
`define IRQ_MERGE_MAP_VH

// Interrupt level driven while latch pending
`define IRQ_LEVEL 3'h7
// Address map: program memory 0x0000-0x0FFF, data memory 0x1000-0x13FF
`define ROM_BASE_HI 4'h0
`define ROM_BANK_BITS 2
`define RAM_BASE_HI 6'h04
// I/O port numbers (8-bit I/O space)
`define IO_BOARD_PORT 8'h00
`define IO_CLR_PORT 8'h01
// One-shot lengths in 5 ns cycles: 1 us and 10 us
`define SHOT0_CYC 13'h00C8
`define SHOT1_CYC 13'h07D0
// Reset values
`define CTRL_RST 8'h00
`endif

// ### verif/cpu_service_model.sv
module cpu_service_model (
  input wire sys_clk, // Clock
  input wire rst_b, // Reset, active low
  input wire irq_req, // Level seven request
  output reg clr_wr // Clear strobe to port 0x01
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [3:0] wait_ff;
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_ff <= 4'h0;
      clr_wr <= 1'b0;
    end else begin
      clr_wr <= irq_req && wait_ff == 4'hF && !clr_wr;
      wait_ff <= irq_req ? wait_ff + (wait_ff != 4'hF) : 4'h0;
    end
  end
endmodule // cpu_service_model

// ### verif/interrupt_merge_and_memory_select_tb.sv
module interrupt_merge_and_memory_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, rst_b = 0, key_press = 0, listener_req = 0, talker_active = 0;
  logic scan_strobe_fifteen = 0, keypad_clk_en = 1, mem_req = 0, io_rd = 0, tb_wr = 0;
  logic [15:0] mem_addr = 0;
  logic [7:0] tb_addr = 0, io_wdata = 0;
  wire clr_wr, irq_req_ff, pending_irq_latch_ff, keypad_clk_gated_ff, dac_hold_ff, ram_sel_ff;
  wire [2:0] irq_level_ff;
  wire [3:0] rom_sel_ff;
  wire [15:0] io_slot_sel_ff;
  wire [7:0] analog_ctrl_ff;
  wire [1:0] delay_one_shots_ff;
  wire io_wr = tb_wr | clr_wr;
  wire [7:0] io_addr = clr_wr ? 8'h01 : tb_addr;
  int num_errors = 0, tests_run = 0, cyc = 0;
  interrupt_merge_and_memory_select DUT (.*);
  cpu_service_model cpu (.sys_clk, .rst_b, .irq_req(irq_req_ff), .clr_wr);
  initial forever #2.5 sys_clk = ~sys_clk;
  // Hang guard, far above the whole sequence
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin num_errors++; complete_run(); end
  end
  task complete_run();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin num_errors++; $display("BAD %0t got %h exp %h", $time, got, exp); end
  endtask
  task tick(input int n); repeat (n) @(posedge sys_clk); #1; endtask
  // Waits for the service model to drop the request
  task wait_idle(); repeat (40) begin tick(1); if (irq_req_ff === 1'b0) break; end endtask
  task t_key();
    @(posedge sys_clk) key_press <= 1;
    tick(2);
    chk(pending_irq_latch_ff, 1);
    chk(irq_level_ff, 3'h7);
    chk(keypad_clk_gated_ff, 0);
    @(posedge sys_clk) key_press <= 0;
    wait_idle();
    chk({irq_req_ff, keypad_clk_gated_ff}, 2'b01);
    @(posedge sys_clk) keypad_clk_en <= 0;
    tick(2);
    chk(keypad_clk_gated_ff, 0);
    @(posedge sys_clk) keypad_clk_en <= 1;
    tick(2);
  endtask
  task t_bus(input logic lis);
    @(posedge sys_clk) begin listener_req <= lis; talker_active <= !lis; end
    tick(3);
    chk(pending_irq_latch_ff, 0);
    @(posedge sys_clk) scan_strobe_fifteen <= 1;
    @(posedge sys_clk) scan_strobe_fifteen <= 0;
    tick(2);
    chk({irq_req_ff, irq_level_ff, dac_hold_ff}, {4'hF, lis});
    @(posedge sys_clk) begin listener_req <= 0; talker_active <= 0; end
    wait_idle();
    chk({irq_req_ff, dac_hold_ff}, 0);
  endtask
  task t_mem();
    logic [15:0] a [7];
    a = '{16'h0000, 16'h07FF, 16'h0800, 16'h0FFF, 16'h1000, 16'h13FF, 16'h1400};
    foreach (a[i]) begin
      @(posedge sys_clk) begin mem_req <= 1; mem_addr <= a[i]; end
      tick(2);
      chk(rom_sel_ff, a[i] < 16'h1000 ? 16'h1 << a[i][11:10] : 0);
      chk(ram_sel_ff, a[i] >= 16'h1000 && a[i] < 16'h1400);
    end
  endtask
  task t_io();
    @(posedge sys_clk) begin tb_wr <= 1; tb_addr <= 8'h00; io_wdata <= 8'h45; end
    @(posedge sys_clk) begin tb_wr <= 0; io_rd <= 1; tb_addr <= 8'h0F; end
    #1 chk({analog_ctrl_ff, delay_one_shots_ff}, {8'h45, 2'b01});
    chk(io_slot_sel_ff, 16'h0001);
    tick(1);
    chk(io_slot_sel_ff, 16'h8000);
    @(posedge sys_clk) io_rd <= 0;
    tick(197);
    chk(delay_one_shots_ff, 2'b01);
    tick(1);
    chk(delay_one_shots_ff, 2'b00);
    @(posedge sys_clk) begin tb_wr <= 1; tb_addr <= 8'h00; io_wdata <= 8'h80; end
    @(posedge sys_clk) tb_wr <= 0;
    #1 chk({analog_ctrl_ff, delay_one_shots_ff}, {8'h80, 2'b10});
    tick(1999);
    chk(delay_one_shots_ff, 2'b10);
    tick(1);
    chk(delay_one_shots_ff, 2'b00);
  endtask
  initial begin
    tick(12);
    rst_b = 1;
    t_key();
    t_bus(1);
    t_bus(0);
    t_mem();
    t_io();
    complete_run();
  end
endmodule // interrupt_merge_and_memory_select_tb

// ### verif/irq_merge_checker.sv
module irq_merge_checker (
  input wire sys_clk, input wire rst_b, input wire key_press, input wire listener_req,
  input wire talker_active, input wire scan_strobe_fifteen, input wire [15:0] mem_addr,
  input wire mem_req, input wire [7:0] io_addr, input wire io_wr, input wire io_rd,
  input wire [7:0] io_wdata, input wire [2:0] irq_level_ff, input wire irq_req_ff,
  input wire pending_irq_latch_ff, input wire keypad_clk_gated_ff, input wire dac_hold_ff,
  input wire [3:0] rom_sel_ff, input wire ram_sel_ff, input wire [15:0] io_slot_sel_ff,
  input wire [7:0] analog_ctrl_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire bus_set;
  assign bus_set = scan_strobe_fifteen && (listener_req || talker_active);
  level_seven_a: assert property (irq_req_ff |-> irq_level_ff == 3'h7)
    else $error("interrupt level not seven");
  key_set_a: assert property (key_press |=> pending_irq_latch_ff)
    else $error("key press did not set latch");
  scan_freeze_a: assert property (pending_irq_latch_ff |=> irq_req_ff && !keypad_clk_gated_ff)
    else $error("pending latch not requesting or scan not frozen");
  latch_clear_a: assert property (io_wr && io_addr == 8'h01 && !key_press && !bus_set
    |=> !pending_irq_latch_ff)
    else $error("clear strobe left latch set");
  bus_set_a: assert property (bus_set |=> pending_irq_latch_ff)
    else $error("bus request at strobe did not set latch");
  dac_hold_a: assert property (dac_hold_ff |-> irq_req_ff)
    else $error("handshake stalled with nothing pending");
  rom_sel_a: assert property (mem_req && mem_addr[15:12] == 4'h0
    |=> rom_sel_ff == (4'h1 << $past(mem_addr[11:10])))
    else $error("wrong program memory select");
  ram_sel_a: assert property (mem_req |=> ram_sel_ff == ($past(mem_addr[15:10]) == 6'h04))
    else $error("wrong data memory select");
  analog_wr_a: assert property (io_wr && io_addr == 8'h00 |=> analog_ctrl_ff == $past(io_wdata))
    else $error("analog lines not written");
  slot_sel_a: assert property ((io_wr || io_rd) && io_addr[7:4] == 4'h0
    |=> io_slot_sel_ff == (16'h0001 << $past(io_addr[3:0])))
    else $error("wrong module select");
  cover property (key_press ##2 irq_req_ff);
  cover property (scan_strobe_fifteen && talker_active ##2 irq_req_ff);
  cover property (dac_hold_ff ##1 !dac_hold_ff);
endmodule // irq_merge_checker
bind interrupt_merge_and_memory_select irq_merge_checker chk (.*);
